// [core/mrs_params.svh]
// Offsets, field positions, reset values and timing counts of the stage sequencer
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH
`define MRS_OFS_REF      8'h00
`define MRS_OFS_DUR      8'h40
`define MRS_OFS_CTRL     8'h80
`define MRS_OFS_STAT     8'h84
`define MRS_OFS_RESUME   8'h88
`define MRS_CB_MODE      0
`define MRS_CB_RETP      4
`define MRS_CB_RETS      5
`define MRS_CB_UNIT      8
`define MRS_CB_SRC       12
`define MRS_CB_RAMP      16
`define MRS_CB_USE       20
`define MRS_CTRL_MASK    32'h0031_7133
`define MRS_CTRL_RST     32'h0000_0000
`define MRS_REF_RST      16'h0000
`define MRS_DUR_RST      16'h0000
`define MRS_REF_MAX      16'sh03e8
`define MRS_REF_MIN      16'shfc18
`define MRS_PCT_FULL     34'sh0_0000_03e8
`define MRS_MODE_STOP    2'h0
`define MRS_MODE_HOLD    2'h1
`define MRS_MODE_LOOP    2'h2
`define MRS_USE_FREQ     2'h0
`define MRS_USE_VOLT     2'h1
`define MRS_SRC_CODE     3'h0
`define MRS_SRC_AI1      3'h1
`define MRS_SRC_PULSE    3'h4
`define MRS_SRC_PID      3'h5
`define MRS_SRC_PRESET   3'h6
`define MRS_SRC_KEYPAD   3'h7
`define MRS_CLK_NS       40
`define MRS_TENTH_S_NS   100000000
`define MRS_TICK_CYC     (`MRS_TENTH_S_NS / `MRS_CLK_NS)
`define MRS_HOUR_TENTHS  12'he10
`endif

// [core/mrs_pkg.sv]
// Types shared by the stage sequencer modules
package mrs_pkg;
  typedef enum logic [3:0] {
    MRS_IDLE = 4'h1,
    MRS_RUN  = 4'h2,
    MRS_HOLD = 4'h4,
    MRS_DONE = 4'h8
  } mrs_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       ret_pwr;
    logic       ret_stop;
    logic       unit_h;
    logic [2:0] src;
    logic       ramp_term;
    logic [1:0] use_as;
  } mrs_cfg_t;

  typedef struct packed {
    logic signed [15:0] ana1;
    logic signed [15:0] pulse;
    logic signed [15:0] pid;
    logic signed [15:0] preset;
    logic signed [15:0] keypad;
  } mrs_src_t;

  typedef struct packed {
    logic signed [16:0] freq;
    logic signed [16:0] volt;
    logic signed [15:0] pid;
  } mrs_ref_out_t;
endpackage

// [core/mrs_stage_timer.sv]
// Stage run-time counter in tenths of a second or tenths of an hour
`include "mrs_params.svh"
module mrs_stage_timer #(
  parameter int unsigned TICK_CYC = `MRS_TICK_CYC
) (
  input  wire logic        i_clk_sys,  // system clock
  input  wire logic        i_reset_n,  // synchronous reset, active low
  input  wire logic        i_restart,  // clear the elapsed time
  input  wire logic        i_unit_h,   // 1: count in hours
  input  wire logic [15:0] i_dur,      // duration in tenths
  output logic             o_expired   // elapsed reached duration
);
  logic [21:0] pre_q;
  logic [11:0] hr_q;
  logic [15:0] el_q;
  wire         tenth_s = (pre_q == 22'(TICK_CYC - 1));
  wire         hr_wrap = (hr_q == `MRS_HOUR_TENTHS - 12'h001);
  wire         unit_tk = tenth_s & (~i_unit_h | hr_wrap);

  assign o_expired = (el_q >= i_dur);

  // --------------------------------------------------------------
  // Prescaler and elapsed count
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || i_restart) begin
      pre_q <= 22'h0;
      hr_q  <= 12'h0;
      el_q  <= 16'h0;
    end else begin
      pre_q <= tenth_s ? 22'h0 : pre_q + 22'h1;
      if (tenth_s) begin
        hr_q <= (hr_wrap || !i_unit_h) ? 12'h0 : hr_q + 12'h1;
      end
      // Saturates so a long hold never wraps back to a short count
      if (unit_tk && !o_expired) begin
        el_q <= el_q + 16'h1;
      end
    end
  end
endmodule

// [core/mrs_scale.sv]
// Scales a tenth-percent reference against a full-scale value
`include "mrs_params.svh"
module mrs_scale (
  input  wire logic               i_clk_sys,  // system clock
  input  wire logic               i_reset_n,  // synchronous reset, active low
  input  wire logic signed [15:0] i_ref,      // reference, tenths of percent
  input  wire logic        [15:0] i_full,     // full-scale value
  output logic signed      [16:0] o_val       // scaled value, registered
);
  wire signed [33:0] prod = 34'(i_ref * $signed({1'b0, i_full}));
  wire signed [33:0] quot = prod / `MRS_PCT_FULL;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_val <= 17'sh0;
    end else begin
      o_val <= quot[16:0];
    end
  end
endmodule

// [core/mrs_seq_top.sv]
// Multi-step reference selector and stage sequencer with APB registers
//
// Design decisions made here: register access over APB and the register offsets.
`include "mrs_params.svh"
module mrs_seq_top #(
  parameter int unsigned TICK_CYC = `MRS_TICK_CYC
) (
  input  wire logic                  i_clk_sys,     // 25 MHz system clock
  input  wire logic                  i_reset_n,     // synchronous reset, active low
  input  wire logic                  i_psel,        // APB select
  input  wire logic                  i_penable,     // APB enable
  input  wire logic                  i_pwrite,      // APB direction
  input  wire logic [7:0]            i_paddr,       // APB byte address
  input  wire logic [31:0]           i_pwdata,      // APB write data
  output logic      [31:0]           o_prdata,      // APB read data
  output logic                       o_pready,      // APB ready
  output logic                       o_pslverr,     // APB error, unmapped address
  input  wire logic                  i_run,         // run command level
  input  wire logic                  i_seq_en,      // sequencer owns the reference
  input  wire logic [3:0]            i_stage_pins,  // stage select terminals
  input  wire logic [1:0]            i_ramp_pins,   // ramp set terminals
  input  wire logic                  i_power_fail,  // power loss warning pin
  input  wire mrs_pkg::mrs_src_t     i_src,         // stage 0 alternative sources
  input  wire logic [15:0]           i_max_freq,    // maximum frequency
  input  wire logic [15:0]           i_rated_volt,  // rated motor voltage
  output mrs_pkg::mrs_ref_out_t      o_ref,         // scaled frequency and voltage references, unscaled PID reference
  output logic                       o_reverse,     // reverse rotation request
  output logic                       o_run_req,     // sequencer wants the drive running
  output logic [1:0]                 o_ramp_set,    // active ramp time set
  output logic [3:0]                 o_stage,       // active stage index
  output logic                       o_seq_done     // single pass finished, stopped
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0]         ref_q [16];
  logic [15:0]         dur_q [16];
  logic [1:0]          rsel_q [16];
  logic [31:0]         ctrl_q;
  logic [3:0]          resume_q;
  logic                pwr_pend_q;
  logic                stop_mid_q;
  logic [3:0]          stage_q;
  logic [3:0]          stage_d;
  mrs_pkg::mrs_state_t st_q;
  mrs_pkg::mrs_state_t st_d;
  logic [6:0]          sy1_q;
  logic [6:0]          sy2_q;
  logic [6:0]          sy3_q;
  logic [6:0]          filt_q;
  logic                pf_prev_q;
  logic                run_prev_q;
  logic [15:0]         pid_q;
  mrs_pkg::mrs_cfg_t   cfg;

  function automatic logic [15:0] mrs_clamp(input logic [15:0] v);
    if ($signed(v) > `MRS_REF_MAX) begin
      return `MRS_REF_MAX;
    end else if ($signed(v) < `MRS_REF_MIN) begin
      return `MRS_REF_MIN;
    end
    return v;
  endfunction

  assign cfg.mode      = ctrl_q[`MRS_CB_MODE +: 2];
  assign cfg.ret_pwr   = ctrl_q[`MRS_CB_RETP];
  assign cfg.ret_stop  = ctrl_q[`MRS_CB_RETS];
  assign cfg.unit_h    = ctrl_q[`MRS_CB_UNIT];
  assign cfg.src       = ctrl_q[`MRS_CB_SRC +: 3];
  assign cfg.ramp_term = ctrl_q[`MRS_CB_RAMP];
  assign cfg.use_as    = ctrl_q[`MRS_CB_USE +: 2];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire       acc      = i_psel & i_penable;
  wire       wr       = acc & i_pwrite;
  wire [3:0] ridx     = i_paddr[5:2];
  wire       in_ref   = (i_paddr[7:6] == 2'b00);
  wire       in_dur   = (i_paddr[7:6] == 2'b01);
  wire       is_ctrl  = (i_paddr == `MRS_OFS_CTRL);
  wire       is_stat  = (i_paddr == `MRS_OFS_STAT);
  wire       is_res   = (i_paddr == `MRS_OFS_RESUME);
  wire       mapped   = in_ref | in_dur | is_ctrl | is_stat | is_res;
  wire [31:0] stat    = {11'h0, o_reverse, 2'h0, o_ramp_set, 2'h0, pwr_pend_q,
                         stop_mid_q, st_q, 4'h0, stage_q};
  wire [31:0] rd_data = in_ref  ? {16'h0, ref_q[ridx]} :
                        in_dur  ? {14'h0, rsel_q[ridx], dur_q[ridx]} :
                        is_ctrl ? ctrl_q :
                        is_stat ? stat :
                        is_res  ? {28'h0, resume_q} : 32'h0;

  // Zero wait states: read data is latched in the setup cycle
  assign o_pready  = acc;
  assign o_pslverr = acc & ~mapped;

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages 2 and 3 agree
  // ----------------------------------------------------------------
  wire [6:0] agree = ~(sy2_q ^ sy3_q);
  wire [3:0] pin_stage = filt_q[3:0];
  wire [1:0] pin_ramp  = filt_q[5:4];
  wire       pf_rise   = filt_q[6] & ~pf_prev_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sy1_q  <= 7'h0;
      sy2_q  <= 7'h0;
      sy3_q  <= 7'h0;
      filt_q <= 7'h0;
    end else begin
      sy1_q  <= {i_power_fail, i_ramp_pins, i_stage_pins};
      sy2_q  <= sy1_q;
      sy3_q  <= sy2_q;
      filt_q <= (sy3_q & agree) | (filt_q & ~agree);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer control
  // ----------------------------------------------------------------
  wire       freq_use = (cfg.use_as == `MRS_USE_FREQ);
  wire       seq_on   = (st_q != mrs_pkg::MRS_IDLE) & i_seq_en;
  wire       start    = i_run & ~run_prev_q & (st_q == mrs_pkg::MRS_IDLE) & i_seq_en;
  wire       stopping = ~i_run & ((st_q == mrs_pkg::MRS_RUN) | (st_q == mrs_pkg::MRS_HOLD));
  wire       use_res  = (pwr_pend_q & cfg.ret_pwr) | (stop_mid_q & cfg.ret_stop);
  wire [3:0] start_st = use_res ? resume_q : 4'h0;
  wire       last     = (stage_q == 4'hf);
  wire       expired;
  wire       restart  = (st_q == mrs_pkg::MRS_IDLE) | (stage_d != stage_q);

  always_comb begin
    st_d    = st_q;
    stage_d = stage_q;
    case (st_q)
      mrs_pkg::MRS_IDLE: begin
        if (start) begin
          st_d    = mrs_pkg::MRS_RUN;
          stage_d = start_st;
        end
      end
      mrs_pkg::MRS_RUN: begin
        if (!i_run) begin
          st_d = mrs_pkg::MRS_IDLE;
        end else if (expired && !last) begin
          stage_d = stage_q + 4'h1;
        end else if (expired && !freq_use) begin
          st_d = mrs_pkg::MRS_HOLD;
        end else if (expired) begin
          case (cfg.mode)
            `MRS_MODE_HOLD: st_d = mrs_pkg::MRS_HOLD;
            `MRS_MODE_LOOP: stage_d = 4'h0;
            default:        st_d = mrs_pkg::MRS_DONE;
          endcase
        end
      end
      mrs_pkg::MRS_HOLD: begin
        if (!i_run) begin
          st_d = mrs_pkg::MRS_IDLE;
        end
      end
      mrs_pkg::MRS_DONE: begin
        if (!i_run) begin
          st_d = mrs_pkg::MRS_IDLE;
        end
      end
      default: st_d = mrs_pkg::MRS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_q       <= mrs_pkg::MRS_IDLE;
      stage_q    <= 4'h0;
      run_prev_q <= 1'b0;
      pf_prev_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      stage_q    <= stage_d;
      run_prev_q <= i_run;
      pf_prev_q  <= filt_q[6];
    end
  end

  // Reset stands for power-up, so a pending restore is armed by it
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      resume_q   <= 4'h0;
      pwr_pend_q <= 1'b1;
      stop_mid_q <= 1'b0;
    end else begin
      if (pf_rise || stopping) begin
        resume_q <= stage_q;
      end else if (wr && is_res) begin
        resume_q <= i_pwdata[3:0];
      end
      if (start) begin
        pwr_pend_q <= 1'b0;
      end
      if (stopping) begin
        stop_mid_q <= 1'b1;
      end else if (start || st_q == mrs_pkg::MRS_DONE) begin
        stop_mid_q <= 1'b0;
      end
    end
  end

  mrs_stage_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_restart (restart),
    .i_unit_h  (cfg.unit_h),
    .i_dur     (dur_q[stage_q]),
    .o_expired (expired)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 16; i++) begin
        ref_q[i]  <= `MRS_REF_RST;
        dur_q[i]  <= `MRS_DUR_RST;
        rsel_q[i] <= 2'h0;
      end
      ctrl_q <= `MRS_CTRL_RST;
    end else if (wr) begin
      if (in_ref) begin
        ref_q[ridx] <= mrs_clamp(i_pwdata[15:0]);
      end
      if (in_dur) begin
        dur_q[ridx]  <= i_pwdata[15:0];
        rsel_q[ridx] <= i_pwdata[17:16];
      end
      if (is_ctrl) begin
        ctrl_q <= i_pwdata & `MRS_CTRL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference selection and outputs
  // ----------------------------------------------------------------
  wire [3:0]  act_idx = seq_on ? stage_q : pin_stage;
  wire [15:0] src0 = (cfg.src == `MRS_SRC_CODE)   ? ref_q[0] :
                     (cfg.src == `MRS_SRC_AI1)    ? i_src.ana1 :
                     (cfg.src == `MRS_SRC_PULSE)  ? i_src.pulse :
                     (cfg.src == `MRS_SRC_PID)    ? i_src.pid :
                     (cfg.src == `MRS_SRC_PRESET) ? i_src.preset :
                     (cfg.src == `MRS_SRC_KEYPAD) ? i_src.keypad : 16'h0;
  wire [15:0] cur_ref = (act_idx == 4'h0) ? src0 : ref_q[act_idx];
  wire        cur_neg = cur_ref[15];
  wire [1:0]  ramp_d  = cfg.ramp_term ? pin_ramp : rsel_q[act_idx];
  wire [15:0] f_in    = freq_use ? cur_ref : 16'h0;
  wire [15:0] v_in    = (cfg.use_as == `MRS_USE_VOLT) ? cur_ref : 16'h0;

  mrs_scale u_fscale (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_ref     (f_in),
    .i_full    (i_max_freq),
    .o_val     (o_ref.freq)
  );

  mrs_scale u_vscale (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_ref     (v_in),
    .i_full    (i_rated_volt),
    .o_val     (o_ref.volt)
  );

  assign o_ref.pid  = pid_q;
  assign o_run_req  = (st_q == mrs_pkg::MRS_RUN) | (st_q == mrs_pkg::MRS_HOLD);
  assign o_seq_done = (st_q == mrs_pkg::MRS_DONE);
  assign o_stage    = stage_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pid_q      <= 16'h0;
      o_reverse  <= 1'b0;
      o_ramp_set <= 2'h0;
      o_prdata   <= 32'h0;
    end else begin
      pid_q      <= cur_ref;
      o_reverse  <= freq_use & cur_neg;
      o_ramp_set <= ramp_d;
      if (i_psel && !i_penable) begin
        o_prdata <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  wire run_end = (st_q == mrs_pkg::MRS_RUN) & i_run & expired & last & freq_use;

  chk_ref_span: assert property ($signed(ref_q[ridx]) <= `MRS_REF_MAX &&
                                 $signed(ref_q[ridx]) >= `MRS_REF_MIN)
    else $error("stored reference outside span");
  chk_dir_sign: assert property (freq_use |=> o_reverse == $past(cur_neg))
    else $error("reverse does not follow reference sign");
  chk_mode0_stop: assert property (run_end && cfg.mode == `MRS_MODE_STOP
                                   |=> o_seq_done && !o_run_req)
    else $error("mode 0 did not stop after pass");
  chk_done_fresh: assert property (o_seq_done && i_run |=> o_seq_done)
    else $error("restart without fresh run command");
  chk_mode1_hold: assert property (run_end && cfg.mode == `MRS_MODE_HOLD
                                   |=> st_q == mrs_pkg::MRS_HOLD && o_stage == 4'hf)
    else $error("mode 1 did not hold last stage");
  chk_mode2_wrap: assert property (run_end && cfg.mode == `MRS_MODE_LOOP
                                   |=> st_q == mrs_pkg::MRS_RUN && o_stage == 4'h0)
    else $error("mode 2 did not wrap to stage 0");
  chk_stop_idle: assert property (stopping |=> !o_run_req && resume_q == $past(stage_q))
    else $error("stop command not obeyed");
  chk_stage_adv: assert property ((st_q == mrs_pkg::MRS_RUN) && i_run && expired && !last
                                  |=> o_stage == $past(stage_q) + 4'h1)
    else $error("stage did not advance");
  chk_fresh_start: assert property (start && !use_res |=> o_stage == 4'h0)
    else $error("non-retentive start not at stage 0");
  chk_ramp_term: assert property (cfg.ramp_term ##1 cfg.ramp_term
                                  |-> o_ramp_set == $past(pin_ramp))
    else $error("terminal ramp set not applied");

  cov_full_pass: cover property (run_end);
  cov_loop_wrap: cover property (run_end && cfg.mode == `MRS_MODE_LOOP);
  cov_resume:    cover property (start && use_res && resume_q != 4'h0);
  cov_reverse:   cover property (seq_on && o_reverse);
endmodule

// [verification/tb.sv]
// Self-checking testbench of the stage sequencer: APB access and stage runs
`include "mrs_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic                  i_clk_sys    = 1'b0;
  logic                  i_reset_n    = 1'b0;
  logic                  i_psel       = 1'b0;
  logic                  i_penable    = 1'b0;
  logic                  i_pwrite     = 1'b0;
  logic [7:0]            i_paddr      = 8'h00;
  logic [31:0]           i_pwdata     = 32'h0000_0000;
  logic                  i_run        = 1'b0;
  logic                  i_seq_en     = 1'b1;
  logic [3:0]            i_stage_pins = 4'h0;
  logic [1:0]            i_ramp_pins  = 2'h0;
  logic                  i_power_fail = 1'b0;
  mrs_pkg::mrs_src_t     i_src        = {16'sh0064, -16'sd200, 16'sh012c, 16'sh0190, -16'sd500};
  logic [15:0]           i_max_freq   = 16'h1388;
  logic [15:0]           i_rated_volt = 16'h0ed8;
  logic [31:0]           o_prdata;
  logic                  o_pready;
  logic                  o_pslverr;
  mrs_pkg::mrs_ref_out_t o_ref;
  logic                  o_reverse;
  logic                  o_run_req;
  logic [1:0]            o_ramp_set;
  logic [3:0]            o_stage;
  logic                  o_seq_done;
  int                    fails        = 0;
  int                    check_count  = 0;
  logic [31:0]           rdat;
  logic                  rerr;

  always #20 i_clk_sys = ~i_clk_sys;

  // Short tick so that each stage lasts a handful of cycles
  mrs_seq_top #(.TICK_CYC(4)) i_dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_run(i_run), .i_seq_en(i_seq_en),
    .i_stage_pins(i_stage_pins), .i_ramp_pins(i_ramp_pins), .i_power_fail(i_power_fail),
    .i_src(i_src), .i_max_freq(i_max_freq), .i_rated_volt(i_rated_volt), .o_ref(o_ref),
    .o_reverse(o_reverse), .o_run_req(o_run_req), .o_ramp_set(o_ramp_set), .o_stage(o_stage),
    .o_seq_done(o_seq_done)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic to();
    fails++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t register got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t output got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask

  // Holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (n == 20) to();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp_reg(rdat, exp);
  endtask

  task automatic rst();
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
  endtask

  task automatic wait_run(input logic v);
    int n;
    for (n = 0; n < 60 && o_run_req !== v; n++) tick();
    if (n == 60) to();
  endtask

  task automatic run(input logic v);
    @(posedge i_clk_sys);
    i_run <= v;
    wait_run(v);
  endtask

  function automatic int rf(input int s);
    return s * 120 - 900;
  endfunction

  function automatic int sc(input int r, input int f);
    return (r * f) / 1000;
  endfunction

  // Waits for stage s, then checks what the stage drives out
  task automatic stg(input int s, input int as_use);
    int n;
    for (n = 0; n < 60 && o_stage !== 4'(s); n++) tick();
    if (n == 60) to();
    repeat (3) tick();
    cmp_out(32'(o_ref.freq), 32'(as_use == 0 ? sc(rf(s), 5000) : 0));
    cmp_out(32'(o_ref.volt), 32'(as_use == 1 ? sc(rf(s), 3800) : 0));
    cmp_out(32'(o_ref.pid), 32'(rf(s)));
    cmp_out({31'h0, o_reverse}, {31'h0, as_use == 0 && rf(s) < 0});
    cmp_out({30'h0, o_ramp_set}, 32'(s % 4));
  endtask

  task automatic pass(input int as_use);
    for (int s = 0; s < 16; s++) stg(s, as_use);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int srcs[7];
    int vals[7];
    srcs = '{0, 1, 2, 4, 5, 6, 7};
    vals = '{-900, 100, 0, -200, 300, 400, -500};
    rst();
    rd(`MRS_OFS_CTRL, 32'h0000_0000);
    rd(`MRS_OFS_REF + 8'h04, 32'h0000_0000);
    rd(`MRS_OFS_STAT, 32'h0000_2100);
    wr(`MRS_OFS_STAT, 32'hffff_ffff);
    rd(`MRS_OFS_STAT, 32'h0000_2100);
    wr(`MRS_OFS_CTRL, 32'hffff_ffff);
    rd(`MRS_OFS_CTRL, `MRS_CTRL_MASK);
    wr(`MRS_OFS_REF + 8'h04, 32'h0000_7fff);
    rd(`MRS_OFS_REF + 8'h04, 32'h0000_03e8);
    wr(`MRS_OFS_REF + 8'h04, 32'h0000_fc00);
    rd(`MRS_OFS_REF + 8'h04, 32'h0000_fc18);
    rd(8'hfc, 32'h0000_0000);
    cmp_reg({31'h0, rerr}, 32'h0000_0001);
    for (int s = 0; s < 16; s++) begin
      wr(`MRS_OFS_REF + 8'(4 * s), {16'h0000, 16'(rf(s))});
      wr(`MRS_OFS_DUR + 8'(4 * s), {14'h0, 2'(s % 4), 16'h0002});
    end
    rd(`MRS_OFS_DUR + 8'h0c, 32'h0003_0002);
    wr(`MRS_OFS_CTRL, 32'h0000_0000);
    run(1'b1);
    pass(0);
    for (int n = 0; n < 60 && o_seq_done !== 1'b1; n++) tick();
    if (o_seq_done !== 1'b1) to();
    repeat (20) tick();
    cmp_out({31'h0, o_seq_done}, 32'h0000_0001);
    cmp_out({31'h0, o_run_req}, 32'h0000_0000);
    run(1'b0);
    run(1'b1);
    cmp_out({28'h0, o_stage}, 32'h0000_0000);
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0000_0001);
    run(1'b1);
    pass(0);
    repeat (50) tick();
    cmp_out({27'h0, o_run_req, o_stage}, 32'h0000_001f);
    // Power-fail edge while holding snapshots the running stage
    @(posedge i_clk_sys);
    i_power_fail <= 1'b1;
    repeat (6) tick();
    rd(`MRS_OFS_RESUME, 32'h0000_000f);
    i_power_fail <= 1'b0;
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0000_0002);
    run(1'b1);
    pass(0);
    stg(0, 0);
    stg(1, 0);
    run(1'b0);
    run(1'b1);
    cmp_out({28'h0, o_stage}, 32'h0000_0000);
    for (int s = 0; s < 5; s++) stg(s, 0);
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0000_0022);
    run(1'b1);
    cmp_out({28'h0, o_stage}, 32'h0000_0004);
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0010_0000);
    run(1'b1);
    pass(1);
    repeat (30) tick();
    cmp_out({27'h0, o_run_req, o_stage}, 32'h0000_001f);
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0020_0000);
    run(1'b1);
    stg(0, 2);
    run(1'b0);
    wr(`MRS_OFS_CTRL, 32'h0000_0100);
    run(1'b1);
    repeat (200) tick();
    cmp_out({28'h0, o_stage}, 32'h0000_0000);
    run(1'b0);
    // Plain multi-reference mode: terminals pick the reference
    @(posedge i_clk_sys);
    i_seq_en     <= 1'b0;
    i_stage_pins <= 4'h5;
    i_ramp_pins  <= 2'h2;
    wr(`MRS_OFS_CTRL, 32'h0001_0000);
    repeat (8) tick();
    cmp_out(32'(o_ref.freq), 32'(sc(rf(5), 5000)));
    cmp_out({30'h0, o_ramp_set}, 32'h0000_0002);
    @(posedge i_clk_sys);
    i_stage_pins <= 4'h0;
    for (int k = 0; k < 7; k++) begin
      wr(`MRS_OFS_CTRL, 32'(srcs[k]) << 12);
      repeat (8) tick();
      cmp_out(32'(o_ref.freq), 32'(sc(vals[k], 5000)));
    end
    @(posedge i_clk_sys);
    i_seq_en <= 1'b1;
    rst();
    wr(`MRS_OFS_CTRL, 32'h0000_0011);
    wr(`MRS_OFS_RESUME, 32'h0000_0007);
    run(1'b1);
    cmp_out({28'h0, o_stage}, 32'h0000_0007);
    run(1'b0);
    rst();
    wr(`MRS_OFS_CTRL, 32'h0000_0001);
    wr(`MRS_OFS_RESUME, 32'h0000_0007);
    run(1'b1);
    cmp_out({28'h0, o_stage}, 32'h0000_0000);
    run(1'b0);
    wrap_up();
  end
endmodule
